// ===== hdl/sabl_regs.svh
`ifndef SABL_REGS_SVH
`define SABL_REGS_SVH

// register byte offsets on the bus
`define SABL_OFF_CTRL    12'h000
`define SABL_OFF_STATUS  12'h004
`define SABL_OFF_MEAS    12'h008
`define SABL_OFF_BAUD    12'h00C
`define SABL_OFF_SERCTL  12'h010
`define SABL_OFF_SYSCFG  12'h014
`define SABL_OFF_BUSCFG  12'h018
`define SABL_OFF_CTXPTR  12'h01C
`define SABL_OFF_STKPTR  12'h020
`define SABL_OFF_STACK_UNDERFLOW_LIMIT   12'h024
`define SABL_OFF_STACK_OVERFLOW_LIMIT   12'h028
`define SABL_RAM_BASE    12'h100
`define SABL_RAM_MASK    12'hF80

// field positions
`define SABL_CTRL_SWRST  0
`define SABL_STAT_OVF    5
`define SABL_MEM_EN_BIT  10
`define SABL_BYTEHI_BIT  9
`define SABL_BUS_ACT_BIT 10
`define SABL_LATCH_BIT   9
`define SABL_BUS_TYP_LSB 6

// values loaded on loader entry, serial setup and branch; redirected flash range
`define SABL_CTXPTR_INIT 16'hFA00
`define SABL_STACK_UNDERFLOW_LIMIT_INIT  16'hFA00
`define SABL_STKPTR_INIT 16'hFA40
`define SABL_STACK_OVERFLOW_LIMIT_INIT  16'hFC00
`define SABL_SYSCFG_INIT 16'h0400
`define SABL_SERCTL_INIT 16'h8011
`define SABL_BRANCH_ADDR 24'h00FA40
`define SABL_RESET_ADDR  24'h000000
`define SABL_FLASH_LO    24'h010000
`define SABL_FLASH_HI    24'h08FFFF

// measurement and timing counts
`define SABL_PRESC_LAST  2'h3
`define SABL_MEAS_MAX    16'hFFFF
`define SABL_MEAS_OFFSET 16'h0024
`define SABL_MEAS_DIV    16'h0048
`define SABL_BIT_SHIFT   5
`define SABL_LOAD_LAST   5'h1F
`define SABL_TX_BITS     4'hA

`endif

// ===== hdl/sabl_pkg.sv
package sabl_pkg;
    // loader sequence
    typedef enum logic [2:0] {
        ST_OFF  = 3'b000,
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_MEAS = 3'b011,
        ST_DIV  = 3'b100,
        ST_ACK  = 3'b101,
        ST_LOAD = 3'b110,
        ST_RUN  = 3'b111
    } sabl_state_t;
    // byte receiver
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } sabl_rx_t;
endpackage : sabl_pkg

// ===== hdl/sabl_ram.sv
`timescale 1ns/1ps
// 32-byte code area, write by loader, registered read for the bus
module sabl_ram (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [4:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [4:0] raddr,
    output logic      [7:0] rdata
);
    logic [7:0] mem [32];  // no reset: contents undefined until loaded

    // write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : sabl_ram

// ===== hdl/sabl_loader.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "sabl_regs.svh"

module sabl_loader
    import sabl_pkg::*;
#(
    parameter logic [7:0] ACK_CODE = 8'h3C  // arbitrary value
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        boot_select_pin,
    input  wire logic        external_access_pin,
    input  wire logic        bus_width_8,
    input  wire logic [1:0]  bus_type_cfg,
    input  wire logic        serial_receive_line,
    output logic             serial_transmit_line,
    output logic             transmit_direction_bit,
    output logic             loader_mode,
    output logic             watchdog_disable,
    input  wire logic        fetch_valid,
    input  wire logic        fetch_is_code,
    input  wire logic [23:0] fetch_addr,
    output logic             fetch_redirect,
    output logic             branch_valid,
    output logic      [23:0] branch_addr
);
    // cycles per serial bit from the reload value
    function automatic logic [15:0] sabl_bit_len(input logic [15:0] rl);
        return 16'((rl + 16'h0001) << `SABL_BIT_SHIFT);
    endfunction : sabl_bit_len

    sabl_state_t state;             // loader sequence
    sabl_state_t state_next;
    sabl_rx_t    rx_st;             // byte receiver
    logic        strap_done;        // strap already sampled
    logic [1:0]  presc;             // clk/4 prescaler for measuring_timer
    logic [15:0] measuring_timer;   // zero-byte length
    logic [15:0] div_rem;           // running remainder
    logic [15:0] div_quot;          // running quotient
    logic [15:0] baud_reload_value; // derived reload
    logic [15:0] serial_control_word;
    logic [15:0] system_config_word;
    logic [15:0] bus_config_word;
    logic [15:0] context_pointer;
    logic [15:0] stack_pointer;
    logic [15:0] stack_underflow_limit;
    logic [15:0] stack_overflow_limit;
    logic        ovf_seen;          // sticky overflow flag
    logic [9:0]  tx_shift;          // stop, data, start
    logic [3:0]  tx_left;           // bits still to send
    logic [15:0] tx_cnt;            // bit timer, transmit
    logic [15:0] rx_cnt;            // bit timer, receive
    logic [2:0]  rx_bit;            // data bit index
    logic [7:0]  rx_sh;             // received byte
    logic [4:0]  load_idx;          // next code byte slot
    logic [7:0]  ram_q;             // code byte read back

    // bus decode
    wire logic apb_acc   = psel && penable;
    wire logic apb_go    = apb_acc && pready;
    wire logic wr_go     = apb_go && pwrite;
    wire logic sw_rst_wr = wr_go && (paddr == `SABL_OFF_CTRL) && pwdata[`SABL_CTRL_SWRST];
    wire logic ovf_clr   = wr_go && (paddr == `SABL_OFF_STATUS) && pwdata[`SABL_STAT_OVF];
    wire logic is_ram    = (paddr & `SABL_RAM_MASK) == `SABL_RAM_BASE;

    // sequence events
    wire logic        strap_now = !strap_done;
    wire logic        meas_tick = (state == ST_MEAS) && (presc == `SABL_PRESC_LAST);
    wire logic        meas_ovf  = meas_tick && (measuring_timer == `SABL_MEAS_MAX);
    wire logic        div_fin   = (state == ST_DIV) && (div_rem < `SABL_MEAS_DIV);
    wire logic [15:0] bit_len   = sabl_bit_len(baud_reload_value);
    wire logic [15:0] half_len  = {1'b0, bit_len[15:1]};
    wire logic        tx_tick   = (tx_left != 4'h0) && (tx_cnt == bit_len - 16'h0001);
    wire logic        rx_full   = rx_cnt == bit_len - 16'h0001;
    wire logic        rx_done   = (rx_st == RX_STOP) && rx_full;
    wire logic        ram_we    = rx_done && (state == ST_LOAD);
    wire logic        last_byte = ram_we && (load_idx == `SABL_LOAD_LAST);
    wire logic        in_flash  = (fetch_addr >= `SABL_FLASH_LO) && (fetch_addr <= `SABL_FLASH_HI);

    // read selection
    wire logic [31:0] stat_word = {24'h000000, 2'h0, ovf_seen, loader_mode, 1'b0, state};
    // misaligned words are refused in the code area as well
    wire logic rd_hit = (paddr[1:0] == 2'h0) && (is_ram || paddr <= `SABL_OFF_STACK_OVERFLOW_LIMIT);
    wire logic [31:0] rd_mux =
        is_ram                         ? {24'h000000, ram_q} :
        paddr == `SABL_OFF_STATUS      ? stat_word :
        paddr == `SABL_OFF_MEAS        ? {16'h0000, measuring_timer} :
        paddr == `SABL_OFF_BAUD        ? {16'h0000, baud_reload_value} :
        paddr == `SABL_OFF_SERCTL      ? {16'h0000, serial_control_word} :
        paddr == `SABL_OFF_SYSCFG      ? {16'h0000, system_config_word} :
        paddr == `SABL_OFF_BUSCFG      ? {16'h0000, bus_config_word} :
        paddr == `SABL_OFF_CTXPTR      ? {16'h0000, context_pointer} :
        paddr == `SABL_OFF_STKPTR      ? {16'h0000, stack_pointer} :
        paddr == `SABL_OFF_STACK_UNDERFLOW_LIMIT       ? {16'h0000, stack_underflow_limit} :
        paddr == `SABL_OFF_STACK_OVERFLOW_LIMIT       ? {16'h0000, stack_overflow_limit} :
                                         32'h00000000;  // control reads zero

    // code area, read through the bus
    sabl_ram u_ram (
        .clk   (pclk),
        .we    (ram_we),
        .waddr (load_idx),
        .wdata (rx_sh),
        .raddr (paddr[6:2]),
        .rdata (ram_q)
    );

    // bus slave: one wait state so the ram read can settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready <= apb_acc && !pready;
            if (apb_acc && !pready) begin
                prdata  <= (pwrite || !rd_hit) ? 32'h00000000 : rd_mux;
                pslverr <= !rd_hit;  // unmapped address
            end
        end
    end

    // next state
    always_comb begin
        state_next = state;
        case (state)
            ST_OFF: begin
                if (strap_now && !boot_select_pin) state_next = ST_IDLE;
            end
            ST_IDLE: begin
                if (serial_receive_line) state_next = ST_WAIT;  // line idle first
            end
            ST_WAIT: begin
                if (!serial_receive_line) state_next = ST_MEAS;  // start bit
            end
            ST_MEAS: begin
                if (meas_ovf) begin
                    state_next = ST_IDLE;  // discard, search again
                end else if (serial_receive_line) begin
                    state_next = ST_DIV;   // stop bit ends the low stretch
                end
            end
            ST_DIV: begin
                if (div_fin) state_next = ST_ACK;
            end
            ST_ACK: begin
                if (tx_left == 4'h0) state_next = ST_LOAD;
            end
            ST_LOAD: begin
                if (last_byte) state_next = ST_RUN;
            end
            ST_RUN: begin
                state_next = ST_RUN;  // loaded code owns the channel
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (sw_rst_wr) state_next = ST_OFF;
    end

    // state and mode flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state            <= ST_OFF;
            strap_done       <= 1'b0;
            loader_mode      <= 1'b0;
            watchdog_disable <= 1'b0;
        end else begin
            state      <= state_next;
            strap_done <= 1'b1;  // strap is looked at once only
            if (strap_now && !boot_select_pin) begin
                loader_mode      <= 1'b1;
                watchdog_disable <= 1'b1;
            end
            if (sw_rst_wr) begin
                loader_mode      <= 1'b0;
                watchdog_disable <= 1'b0;
            end
        end
    end

    // configuration words preset on entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            context_pointer       <= 16'h0000;
            stack_pointer         <= 16'h0000;
            stack_underflow_limit <= 16'h0000;
            stack_overflow_limit  <= 16'h0000;
            system_config_word    <= 16'h0000;
            bus_config_word       <= 16'h0000;
        end else if (strap_now && !boot_select_pin) begin
            context_pointer       <= `SABL_CTXPTR_INIT;
            stack_pointer         <= `SABL_STKPTR_INIT;
            stack_underflow_limit <= `SABL_STACK_UNDERFLOW_LIMIT_INIT;
            stack_overflow_limit  <= `SABL_STACK_OVERFLOW_LIMIT_INIT;
            system_config_word    <= `SABL_SYSCFG_INIT;
            system_config_word[`SABL_MEM_EN_BIT] <= 1'b1;
            system_config_word[`SABL_BYTEHI_BIT] <= bus_width_8;
            bus_config_word <= 16'h0000;  // external bus off
            if (!external_access_pin) begin
                bus_config_word[`SABL_BUS_ACT_BIT] <= 1'b1;
                bus_config_word[`SABL_LATCH_BIT]   <= 1'b1;
                bus_config_word[`SABL_BUS_TYP_LSB +: 2] <= bus_type_cfg;
            end
        end
    end

    // zero-byte measurement and reload division
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc           <= 2'h0;
            measuring_timer <= 16'h0000;
            div_rem         <= 16'h0000;
            div_quot        <= 16'h0000;
        end else if (state == ST_WAIT) begin
            presc           <= 2'h0;
            measuring_timer <= 16'h0000;
        end else if (state == ST_MEAS) begin
            presc <= presc + 2'h1;
            if (meas_tick) measuring_timer <= measuring_timer + 16'h0001;
            // below the offset the result is simply reload zero, the fastest rate
            div_rem  <= (measuring_timer >= `SABL_MEAS_OFFSET) ?
                        measuring_timer - `SABL_MEAS_OFFSET : 16'h0000;
            div_quot <= 16'h0000;
        end else if (state == ST_DIV && !div_fin) begin
            div_rem  <= div_rem - `SABL_MEAS_DIV;  // restoring divide by 72
            div_quot <= div_quot + 16'h0001;
        end
    end

    // overflow flag, set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_seen <= 1'b0;
        end else begin
            ovf_seen <= meas_ovf || (ovf_seen && !ovf_clr);
        end
    end

    // serial channel setup and acknowledge transmitter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_reload_value      <= 16'h0000;
            serial_control_word    <= 16'h0000;
            transmit_direction_bit <= 1'b0;
            serial_transmit_line   <= 1'b1;
            tx_shift               <= 10'h3FF;
            tx_left                <= 4'h0;
            tx_cnt                 <= 16'h0000;
        end else begin
            serial_transmit_line <= (tx_left != 4'h0) ? tx_shift[0] : 1'b1;
            if (div_fin) begin
                baud_reload_value      <= div_quot;
                serial_control_word    <= `SABL_SERCTL_INIT;
                transmit_direction_bit <= 1'b1;               // driven only now
                tx_shift <= {1'b1, ACK_CODE, 1'b0};
                tx_left  <= `SABL_TX_BITS;
                tx_cnt   <= 16'h0000;
            end else if (tx_left != 4'h0) begin
                tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
                if (tx_tick) begin
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_left  <= tx_left - 4'h1;
                end
            end
            if (sw_rst_wr) transmit_direction_bit <= 1'b0;
        end
    end

    // code byte receiver, mid-bit sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st    <= RX_IDLE;
            rx_cnt   <= 16'h0000;
            rx_bit   <= 3'h0;
            rx_sh    <= 8'h00;
            load_idx <= 5'h00;
        end else if (state != ST_LOAD) begin
            rx_st    <= RX_IDLE;
            load_idx <= 5'h00;
        end else begin
            rx_cnt <= rx_cnt + 16'h0001;
            case (rx_st)
                RX_IDLE: begin
                    rx_cnt <= 16'h0000;
                    if (!serial_receive_line) rx_st <= RX_START;
                end
                RX_START: begin
                    if (rx_cnt == half_len - 16'h0001) begin
                        rx_cnt <= 16'h0000;
                        rx_bit <= 3'h0;
                        // a glitch shorter than half a bit is ignored
                        rx_st  <= serial_receive_line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_full) begin
                        rx_cnt <= 16'h0000;
                        rx_sh  <= {serial_receive_line, rx_sh[7:1]};  // lsb first
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'h7) rx_st <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_full) begin
                        rx_st    <= RX_IDLE;  // stop level not checked
                        load_idx <= load_idx + 5'h01;
                    end
                end
                default: begin
                    rx_st <= RX_IDLE;
                end
            endcase
        end
    end

    // branch request and fetch redirection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            branch_valid   <= 1'b0;
            branch_addr    <= `SABL_RESET_ADDR;
            fetch_redirect <= 1'b0;
        end else begin
            branch_valid <= last_byte || sw_rst_wr;
            if (last_byte) branch_addr <= `SABL_BRANCH_ADDR;
            if (sw_rst_wr) branch_addr <= `SABL_RESET_ADDR;
            // data reads keep seeing the program store
            fetch_redirect <= loader_mode && fetch_valid && fetch_is_code && in_flash;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_last_byte;
        (state == ST_LOAD) ##0 last_byte;
    endsequence
    sequence s_div_done;
        (state == ST_DIV) ##1 (state == ST_ACK);
    endsequence

    a_strap_entry: assert property ((state == ST_OFF) && strap_now && !boot_select_pin
        |=> loader_mode && watchdog_disable && (state == ST_IDLE))
        else $error("loader not entered on low strap");
    a_strap_skip: assert property (strap_now && boot_select_pin |=> !loader_mode [*2])
        else $error("loader entered on high strap");
    a_sw_exit: assert property (sw_rst_wr |=> !loader_mode && branch_valid
        && (branch_addr == `SABL_RESET_ADDR))
        else $error("software reset did not leave loader");
    a_wdog_off: assert property (loader_mode |-> watchdog_disable)
        else $error("watchdog active in loader mode");
    a_ovf_retry: assert property (meas_ovf |=> (state == ST_IDLE) && ovf_seen
        && !transmit_direction_bit)
        else $error("overflow not discarded");
    // the final tick may land in the cycle whose count feeds the divider
    a_reload_calc: assert property (s_div_done
        |-> ((measuring_timer < `SABL_MEAS_OFFSET) ? (baud_reload_value == 16'h0000) :
        ((32'(baud_reload_value) * 32'h48 + 32'h24 <= 32'(measuring_timer))
        && (32'(measuring_timer) <= 32'(baud_reload_value) * 32'h48 + 32'h6C))))
        else $error("reload value out of range");
    a_ser_setup: assert property (s_div_done
        |-> (serial_control_word == `SABL_SERCTL_INIT) && transmit_direction_bit
        ##1 !serial_transmit_line)
        else $error("serial channel not set up before acknowledge");
    a_tx_quiet: assert property ((state == ST_MEAS) || (state == ST_DIV)
        |-> !transmit_direction_bit)
        else $error("transmit driven before measurement done");
    a_last_byte: assert property (s_last_byte |=> (state == ST_RUN) && branch_valid
        && (branch_addr == `SABL_BRANCH_ADDR) && loader_mode)
        else $error("no branch after last code byte");
    a_fetch_map: assert property (fetch_valid && !fetch_is_code |=> !fetch_redirect)
        else $error("data read redirected");
    a_cfg_entry: assert property ($rose(loader_mode)
        |-> system_config_word[`SABL_MEM_EN_BIT] && (stack_pointer == `SABL_STKPTR_INIT)
        && (context_pointer == `SABL_CTXPTR_INIT))
        else $error("loader configuration not preset");
endmodule : sabl_loader

// ===== test/sabl_host.sv
`timescale 1ns/1ps
// host partner: zero byte, ack capture, then 32 code bytes
module sabl_host #(parameter int P = 64) (
    input  wire logic         clk,
    input  wire logic         go,
    input  wire logic [255:0] code,
    input  wire logic         tx_line,
    input  wire logic         tx_dir,
    output logic              rx_line,
    output logic        [7:0] ack_seen,
    output logic              done
);
    // 8n1 byte lsb first; long stop lets the loader re-arm
    task automatic send_byte(input logic [7:0] b);
        rx_line <= 1'b0;
        repeat (P) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rx_line <= b[i];
            repeat (P) @(posedge clk);
        end
        rx_line <= 1'b1;
        repeat (2 * P) @(posedge clk);
    endtask : send_byte
    // one boot conversation per run
    initial begin
        rx_line = 1'b1;  // idle high, as the pull-up holds it
        ack_seen = 8'h00;
        done = 1'b0;
        wait (go === 1'b1);
        repeat (P) @(posedge clk);  // init time allowance
        rx_line <= 1'b0;  // start bit plus eight zeros
        repeat (9 * P) @(posedge clk);
        rx_line <= 1'b1;  // stop bit ends the measurement
        wait (tx_dir === 1'b1 && tx_line === 1'b0);  // line trusted once driven
        repeat (P + P / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            ack_seen[i] = tx_line;  // mid-bit at our own rate
            repeat (P) @(posedge clk);
        end
        repeat (P) @(posedge clk);  // wait out the ack stop bit
        for (int i = 0; i < 32; i++) send_byte(code[8 * i +: 8]);
        done = 1'b1;
    end
endmodule : sabl_host

// ===== test/serial_autobaud_boot_loader_bench.sv
`timescale 1ns/1ps
module serial_autobaud_boot_loader_bench;
    localparam int P = 64;  // fast host rate, exact match, no timer overflow
    localparam logic [7:0] ACK = 8'hA7;  // arbitrary value
    localparam logic [31:0] RELOAD = 32'((9 * P / 4 - 36) / 72);
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h00010A3E;
    logic pready, pslverr, err, go = 1'b0, host_done, fetch_valid = 1'b0;
    logic boot_select_pin = 1'b0, external_access_pin = 1'b0, bus_width_8 = 1'b0;
    logic [1:0] bus_type_cfg = 2'h0;
    logic serial_receive_line, serial_transmit_line, transmit_direction_bit;
    logic loader_mode, watchdog_disable, fetch_redirect, branch_valid, fetch_is_code = 1'b0;
    logic [23:0] fetch_addr = 24'h0, branch_addr, br_a = 24'h0;
    logic [7:0] ack_seen;
    logic [255:0] code = '0;
    int fails = 0, check_count = 0, br_n = 0, n0;
    always #4 pclk = ~pclk;  // 125 mhz
    sabl_loader #(.ACK_CODE(ACK)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_select_pin,
        .external_access_pin, .bus_width_8, .bus_type_cfg, .serial_receive_line,
        .serial_transmit_line, .transmit_direction_bit, .loader_mode, .watchdog_disable,
        .fetch_valid, .fetch_is_code, .fetch_addr, .fetch_redirect, .branch_valid,
        .branch_addr);
    sabl_host #(.P(P)) host (.clk(pclk), .go, .code, .tx_line(serial_transmit_line),
        .tx_dir(transmit_direction_bit), .rx_line(serial_receive_line), .ack_seen,
        .done(host_done));
    // branch pulses are one cycle wide, so count them here
    always @(posedge pclk) if (branch_valid === 1'b1) begin
        br_n <= br_n + 1;
        br_a <= branch_addr;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // expected config words from the straps
    function automatic logic [31:0] exp_sys();
        return {21'h0, 1'b1, bus_width_8, 9'h0};
    endfunction : exp_sys
    function automatic logic [31:0] exp_bus();
        return external_access_pin ? 32'h0 : {21'h0, 3'h6, bus_type_cfg, 6'h0};
    endfunction : exp_bus
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    // request held until pready is sampled high; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rd_chk
    // reset with random width and bus type straps
    task automatic do_reset(input logic bs, input logic ea);
        seed = xs(seed);
        @(posedge pclk);
        presetn <= 1'b0;
        boot_select_pin <= bs;
        external_access_pin <= ea;
        bus_width_8 <= seed[0];
        bus_type_cfg <= seed[2:1];
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
    endtask : do_reset
    task automatic fetch_chk(input logic [23:0] a, input logic c, input logic e);
        @(posedge pclk);
        fetch_valid <= 1'b1;
        fetch_is_code <= c;
        fetch_addr <= a;
        @(posedge pclk);
        fetch_valid <= 1'b0;
        #1 chk("redirect", e, fetch_redirect);
    endtask : fetch_chk
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial begin
        do_reset(1'b0, 1'b1);
        rd_chk("syscfg", 12'h014, exp_sys());
        rd_chk("buscfg", 12'h018, exp_bus());
        $display("test straps done");
        do_reset(1'b0, 1'b0);
        chk("loader", 1, loader_mode);
        chk("wdog off", 1, watchdog_disable);
        chk("tx dir", 0, transmit_direction_bit);
        rd_chk("ctxptr", 12'h01C, 32'hFA00);
        rd_chk("stkptr", 12'h020, 32'hFA40);
        rd_chk("stack_underflow_limit", 12'h024, 32'hFA00);
        rd_chk("stack_overflow_limit", 12'h028, 32'hFC00);
        rd_chk("syscfg", 12'h014, exp_sys());
        rd_chk("buscfg", 12'h018, exp_bus());
        rd_chk("unmapped", 12'h02C, 32'h0);
        chk("slverr", 1, err);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            code[32 * i +: 32] = seed;
        end
        n0 = br_n;
        go = 1'b1;
        wait (host_done === 1'b1);
        chk("ack", ACK, ack_seen);
        chk("tx dir", 1, transmit_direction_bit);
        chk("branches", n0 + 1, br_n);
        chk("target", 32'h00FA40, br_a);
        chk("loader", 1, loader_mode);
        rd_chk("meas", 12'h008, 32'(9 * P / 4));
        rd_chk("reload", 12'h00C, RELOAD);
        rd_chk("serctl", 12'h010, 32'h8011);
        rd_chk("status", 12'h004, 32'h17);
        for (int i = 0; i < 32; i++) rd_chk("code", 12'h100 + 12'(4 * i), code[8 * i +: 8]);
        $display("test serial_boot done");
        fetch_chk(24'h00FFFF, 1'b1, 1'b0);
        fetch_chk(24'h010000, 1'b1, 1'b1);
        fetch_chk(24'h08FFFF, 1'b1, 1'b1);
        fetch_chk(24'h090000, 1'b1, 1'b0);
        fetch_chk(24'h010000 + seed[18:0], 1'b1, 1'b1);
        fetch_chk(24'h020000, 1'b0, 1'b0);
        n0 = br_n;
        apb(1'b1, 12'h000, 32'h1);  // software reset
        repeat (4) @(posedge pclk);
        #1 chk("loader", 0, loader_mode);
        chk("branches", n0 + 1, br_n);
        chk("target", 0, br_a);
        fetch_chk(24'h010000, 1'b1, 1'b0);
        do_reset(1'b1, 1'b0);
        chk("loader", 0, loader_mode);
        chk("wdog off", 0, watchdog_disable);
        $display("test exit done");
        give_verdict();
    end
    // hang guard, about two and a half times the expected run
    initial begin
        repeat (60000) @(posedge pclk);
        fails++;
        give_verdict();
    end
endmodule : serial_autobaud_boot_loader_bench
